// file: logic/mcs_pkg.sv
// constants, register map and field layouts of the multichip sync block
// assumes a simple byte-wide register port and a directly sourced sample clock
// How it works
// - writing 0xC8 to sync control selects periodic data-rate resynchronization
// - writing 0x88 to sync control selects periodic FIFO-rate resynchronization
// - locked bit 6 sets once phase is constant, within (11+avg)*64..128 cycles
// - meeting sampling needs, all devices update outputs within one sample clock
// - locked event may raise an interrupt request when enabled
// - lost bit 7 sets on loss of alignment and holds until overwritten
// - phase readback is unsigned 6.2; upper six bits give state 0..63
// - with averaging, low two readback bits give quarter state; 00 is clean
// - FIFO-rate mode synchronizes at data rate divided by FIFO depth eight
// - control bit 3 picks reference sampling edge; bits 2..0 set averaging 1..128
package mcs_pkg;
	localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h04;
	localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h06;
	localparam logic [7:0] ADDR_SYNC_CTRL = 8'h10;
	localparam logic [7:0] ADDR_SYNC_STATUS = 8'h12;
	localparam logic [7:0] ADDR_PHASE_RB = 8'h13;
	localparam logic [7:0] ADDR_DCLK_DELAY = 8'h16;
	localparam int STATUS_LOCKED = 6;
	localparam int STATUS_LOST = 7;
	localparam int EVENT_LOCKED = 4;
	localparam int EVENT_LOST = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_DATA_RATE = 8'hC8;
	localparam logic [7:0] CTRL_FIFO_RATE = 8'h88;
	localparam logic [15:0] LOCK_BASE = 16'h000B;
	localparam int LOCK_UNIT_MIN = 64;
	localparam int LOCK_UNIT_MAX = 128;
	localparam logic [2:0] FIFO_LAST_WORD = 3'h7;
	localparam int SYNC_STAGES = 3;
	// sync control layout
	typedef struct packed {
		logic enable;
		logic data_rate;
		logic [1:0] spare;
		logic rise_edge;
		logic [2:0] avg_log2;
	} mcs_ctrl_t;
	// one finished averaging window
	typedef struct packed {
		logic done;
		logic [7:0] phase_q;
	} mcs_meas_t;
endpackage

// file: logic/mcs_sync_top.sv
// multichip sync core: reference alignment, lock/lost status, frame FIFO reset
// assumes sys_clk_i is the sample clock and input_data_clock_i comes from the source
`timescale 1ns/10ps
module mcs_sync_top #(
	parameter int LOCK_UNIT = mcs_pkg::LOCK_UNIT_MIN
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic input_data_clock_i,
	input wire logic frame_i,
	input wire logic sync_reference_clock_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic [5:0] cgen_phase_o,
	output logic fifo_reset_o,
	output logic update_o,
	output logic event_req_o
);
	// link domain: reset, frame capture window, word counter
	logic lrst1, lrst;
	logic [2:0] dc1, dc2, dc3;
	logic [1:0] dly_use;
	logic [3:0] frame_line;
	logic frame_prev;
	logic [2:0] word_cnt;
	logic fr_tgl, fifo_tgl, data_tgl;
	wire frame_sel = frame_line[dly_use];
	wire frame_rise = frame_sel & ~frame_prev;

	// registers and sys-domain state
	mcs_pkg::mcs_ctrl_t ctrl;
	logic [1:0] dclk_delay;
	logic [7:0] ev_en;
	logic ev_lock_lat, ev_lost_lat;
	logic locked, lost, locked_prev, lost_prev;
	logic [5:0] cgen_phase;
	logic [7:0] phase_rb;
	logic [7:0] win_cnt;
	logic [13:0] win_sum;
	logic [15:0] lock_cnt;

	// reset crossing into the link domain; a stopped clock delays both assertion and release
	always_ff @(posedge input_data_clock_i)
	begin
		lrst1 <= sys_rst_i;
		lrst <= lrst1;
	end

	// delay code crossing: quasi-static, taken only once two late stages agree
	always_ff @(posedge input_data_clock_i)
	begin
		dc1 <= {1'b0, dclk_delay};
		dc2 <= dc1;
		dc3 <= dc2;
	end

	// later taps of the frame line give later capture windows
	always_ff @(posedge input_data_clock_i)
	begin
		if (lrst)
		begin
			dly_use <= 2'h0;
			frame_line <= 4'h0;
			frame_prev <= 1'b0;
		end
		else
		begin
			if (dc2 == dc3)
				dly_use <= dc3[1:0];
			frame_line <= {frame_line[2:0], frame_i};
			frame_prev <= frame_sel;
		end
	end

	// frame rising edge restarts the eight word FIFO count
	always_ff @(posedge input_data_clock_i)
	begin
		if (lrst)
		begin
			word_cnt <= 3'h0;
			fr_tgl <= 1'b0;
			fifo_tgl <= 1'b0;
			data_tgl <= 1'b0;
		end
		else
		begin
			data_tgl <= ~data_tgl;
			word_cnt <= frame_rise ? 3'h0 : word_cnt + 3'h1;
			if (frame_rise)
				fr_tgl <= ~fr_tgl;
			if (!frame_rise && word_cnt == mcs_pkg::FIFO_LAST_WORD)
				fifo_tgl <= ~fifo_tgl;
		end
	end

	// crossings into sys domain: reference pin and three event toggles
	logic [3:0] xin, xst, xchg;
	assign xin = {data_tgl, fifo_tgl, fr_tgl, sync_reference_clock_i};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_xing
			logic [mcs_pkg::SYNC_STAGES-1:0] sh;
			logic st;
			assign xchg[gi] = (sh[1] == sh[2]) && (sh[2] != st);
			assign xst[gi] = st;
			always_ff @(posedge sys_clk_i)
			begin
				sh <= {sh[1:0], xin[gi]};
				if (sys_rst_i)
					st <= 1'b0;
				else if (sh[1] == sh[2])
					st <= sh[2];
			end
		end
	endgenerate

	// reference edge per the selected sampling edge
	wire ref_evt = xchg[0] && (~xst[0] == ctrl.rise_edge);
	wire frame_evt = xchg[1];
	wire rate_evt = ctrl.data_rate ? xchg[3] : xchg[2];

	// averaging window: size 1..128, phase result in 6.2 format
	wire [7:0] avg_n = 8'h01 << ctrl.avg_log2;
	wire [13:0] win_total = win_sum + {8'h00, cgen_phase};
	wire [15:0] win_scaled = {win_total, 2'b00} >> ctrl.avg_log2;
	mcs_pkg::mcs_meas_t meas;
	assign meas.done = ctrl.enable && ref_evt && (win_cnt + 8'h01 == avg_n);
	assign meas.phase_q = win_scaled[7:0];
	wire corr = meas.done && (meas.phase_q[7:2] != 6'h00);
	wire [15:0] lock_need = 16'((mcs_pkg::LOCK_BASE + {8'h00, avg_n}) * LOCK_UNIT);
	wire next_locked = ctrl.enable && !corr && (lock_cnt >= lock_need);

	// clock generation state machine; a correction pulls the phase back to zero
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			cgen_phase <= 6'h00;
		else
			cgen_phase <= cgen_phase + 6'h01 - (corr ? meas.phase_q[7:2] : 6'h00);
	end

	// phase averaging accumulator; restarts whenever sync is off
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || !ctrl.enable || meas.done)
		begin
			win_cnt <= 8'h00;
			win_sum <= 14'h0000;
		end
		else if (ref_evt)
		begin
			win_cnt <= win_cnt + 8'h01;
			win_sum <= win_total;
		end
	end

	// readback holds the last averaged phase
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			phase_rb <= 8'h00;
		else if (meas.done)
			phase_rb <= meas.phase_q;
	end

	// lock timer counts cycles of constant phase and saturates
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || !ctrl.enable || corr)
			lock_cnt <= 16'h0000;
		else if (lock_cnt != 16'hFFFF)
			lock_cnt <= lock_cnt + 16'h0001;
	end

	// status: lost is sticky, set beats the overwrite that clears it
	wire wr_status = reg_wr_i && reg_addr_i == mcs_pkg::ADDR_SYNC_STATUS;
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			locked <= 1'b0;
			lost <= 1'b0;
		end
		else
		begin
			locked <= next_locked;
			if (locked && corr)
				lost <= 1'b1;
			else if (wr_status)
				lost <= 1'b0;
		end
	end

	// software-written registers
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl <= mcs_pkg::CTRL_RESET;
			dclk_delay <= 2'h0;
			ev_en <= 8'h00;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == mcs_pkg::ADDR_SYNC_CTRL)
				ctrl <= reg_wdata_i;
			if (reg_addr_i == mcs_pkg::ADDR_DCLK_DELAY)
				dclk_delay <= reg_wdata_i[1:0];
			if (reg_addr_i == mcs_pkg::ADDR_EVENT_ENABLE)
				ev_en <= reg_wdata_i;
		end
	end

	// event flags latch rising sources while enabled; write one clears, set wins
	wire wr_flags = reg_wr_i && reg_addr_i == mcs_pkg::ADDR_EVENT_FLAGS;
	wire lock_rise = locked && !locked_prev;
	wire lost_rise = lost && !lost_prev;
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			locked_prev <= 1'b0;
			lost_prev <= 1'b0;
			ev_lock_lat <= 1'b0;
			ev_lost_lat <= 1'b0;
		end
		else
		begin
			locked_prev <= locked;
			lost_prev <= lost;
			if (lock_rise && ev_en[mcs_pkg::EVENT_LOCKED])
				ev_lock_lat <= 1'b1;
			else if (wr_flags && reg_wdata_i[mcs_pkg::EVENT_LOCKED])
				ev_lock_lat <= 1'b0;
			if (lost_rise && ev_en[mcs_pkg::EVENT_LOST])
				ev_lost_lat <= 1'b1;
			else if (wr_flags && reg_wdata_i[mcs_pkg::EVENT_LOST])
				ev_lost_lat <= 1'b0;
		end
	end

	// disabled flags show the live source instead of the latch
	wire ev_lock_bit = ev_en[mcs_pkg::EVENT_LOCKED] ? ev_lock_lat : locked;
	wire ev_lost_bit = ev_en[mcs_pkg::EVENT_LOST] ? ev_lost_lat : lost;
	wire [7:0] flags_rd = {2'b00, ev_lost_bit, ev_lock_bit, 4'h0};
	wire [7:0] status_rd = {lost, locked, 6'h00};
	wire [7:0] rd_mux =
		(reg_addr_i == mcs_pkg::ADDR_EVENT_ENABLE) ? ev_en :
		(reg_addr_i == mcs_pkg::ADDR_EVENT_FLAGS) ? flags_rd :
		(reg_addr_i == mcs_pkg::ADDR_SYNC_CTRL) ? ctrl :
		(reg_addr_i == mcs_pkg::ADDR_SYNC_STATUS) ? status_rd :
		(reg_addr_i == mcs_pkg::ADDR_PHASE_RB) ? phase_rb :
		(reg_addr_i == mcs_pkg::ADDR_DCLK_DELAY) ? {6'h00, dclk_delay} : 8'h00;

	// registered outputs: read data, FIFO reset and output update strobes
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			reg_rdata_o <= 8'h00;
			fifo_reset_o <= 1'b0;
			update_o <= 1'b0;
		end
		else
		begin
			if (reg_rd_i)
				reg_rdata_o <= rd_mux;
			fifo_reset_o <= frame_evt;
			update_o <= locked && rate_evt;
		end
	end

	assign cgen_phase_o = cgen_phase;
	assign event_req_o = ev_lock_lat | ev_lost_lat;

	// checks
	sequence s_locked_corr;
		locked && corr;
	endsequence
	property p_lost_on_unlock;
		@(posedge sys_clk_i) disable iff (sys_rst_i) s_locked_corr |=> lost && !locked;
	endproperty
	a_lost_on_unlock: assert property (p_lost_on_unlock) else $error("lost not set on unlock");
	property p_lost_holds;
		@(posedge sys_clk_i) disable iff (sys_rst_i) lost && !wr_status |=> lost;
	endproperty
	a_lost_holds: assert property (p_lost_holds) else $error("lost cleared without write");
	property p_lock_time;
		@(posedge sys_clk_i) disable iff (sys_rst_i) $rose(locked) |-> $past(lock_cnt) >= lock_need;
	endproperty
	a_lock_time: assert property (p_lock_time) else $error("locked too early");
	property p_ctrl_data_rate;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == mcs_pkg::ADDR_SYNC_CTRL && reg_wdata_i == mcs_pkg::CTRL_DATA_RATE
		|=> ctrl.enable && ctrl.data_rate && ctrl.rise_edge;
	endproperty
	a_ctrl_data_rate: assert property (p_ctrl_data_rate) else $error("data rate mode not set");
	property p_ctrl_fifo_rate;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == mcs_pkg::ADDR_SYNC_CTRL && reg_wdata_i == mcs_pkg::CTRL_FIFO_RATE
		|=> ctrl.enable && !ctrl.data_rate;
	endproperty
	a_ctrl_fifo_rate: assert property (p_ctrl_fifo_rate) else $error("fifo rate mode not set");
	property p_frac_zero;
		@(posedge sys_clk_i) disable iff (sys_rst_i) meas.done && ctrl.avg_log2 == 3'h0 |=> phase_rb[1:0] == 2'b00;
	endproperty
	a_frac_zero: assert property (p_frac_zero) else $error("fraction set without averaging");
	property p_phase_rb;
		@(posedge sys_clk_i) disable iff (sys_rst_i) meas.done |=> phase_rb == $past(meas.phase_q);
	endproperty
	a_phase_rb: assert property (p_phase_rb) else $error("phase readback not updated");
	property p_lock_event;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		lock_rise && ev_en[mcs_pkg::EVENT_LOCKED] |=> ev_lock_lat && event_req_o;
	endproperty
	a_lock_event: assert property (p_lock_event) else $error("locked event not raised");
	property p_fifo_reset;
		@(posedge sys_clk_i) disable iff (sys_rst_i) frame_evt |=> fifo_reset_o ##1 !fifo_reset_o;
	endproperty
	a_fifo_reset: assert property (p_fifo_reset) else $error("fifo reset not one pulse");
	property p_no_lock_off;
		@(posedge sys_clk_i) disable iff (sys_rst_i) !ctrl.enable |=> !locked;
	endproperty
	a_no_lock_off: assert property (p_no_lock_off) else $error("locked while disabled");
endmodule // mcs_sync_top

// file: sim/mcs_src_model.sv
// data source model: free data clock, reference from the sample clock, frame strobe
// assumes sys_clk_i is the sample clock that the reference must be aligned to
`timescale 1ns/10ps
module mcs_src_model (
	input wire logic sys_clk_i,
	output logic input_data_clock_o,
	output logic frame_o,
	output logic sync_reference_clock_o
);
	int ref_cnt = 0;
	int extra = 0;
	// data clock runs free at a fixed rate so its drift stays bounded
	initial
	begin
		input_data_clock_o = 1'b0;
		forever #15 input_data_clock_o = ~input_data_clock_o;
	end
	// reference is steady from time zero, before sync is ever enabled
	initial
	begin
		sync_reference_clock_o = 1'b0;
		frame_o = 1'b0;
	end
	// toggles every 32 sample clocks, well below the data rate and just below data rate over 8
	always @(negedge sys_clk_i)
	begin
		if (extra > 0)
			extra <= extra - 1;
		else if (ref_cnt == 31)
		begin
			ref_cnt <= 0;
			sync_reference_clock_o <= ~sync_reference_clock_o;
		end
		else
			ref_cnt <= ref_cnt + 1;
	end
	// stretch one half period once to knock the phase off
	task automatic jump();
		extra = 8;
	endtask
	// falling edge to falling edge: exactly one rising data clock edge sees it
	task automatic send_frame();
		@(negedge input_data_clock_o);
		frame_o = 1'b1;
		@(negedge input_data_clock_o);
		frame_o = 1'b0;
	endtask
endmodule // mcs_src_model

// file: sim/tb_top.sv
// self-checking bench for the multichip sync core
// assumes the source model supplies data clock, frame and reference
`timescale 1ns/10ps
module tb_top;
	logic sys_clk;
	logic sys_rst;
	logic dclk;
	logic frame;
	logic sync_reference_clock;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] v;
	logic wr;
	logic rd;
	logic fifo_rst;
	logic upd;
	logic evreq;
	logic [5:0] phase;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int cu;
	int cf;
	// default lock unit: a shorter timer would lock between two reference edges and fake a loss
	mcs_sync_top mcs_sync_top_i (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
		.input_data_clock_i(dclk), .frame_i(frame), .sync_reference_clock_i(sync_reference_clock),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .cgen_phase_o(phase), .fifo_reset_o(fifo_rst),
		.update_o(upd), .event_req_o(evreq));
	mcs_src_model mcs_src_model_i (.sys_clk_i(sys_clk), .input_data_clock_o(dclk),
		.frame_o(frame), .sync_reference_clock_o(sync_reference_clock));
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// hang guard, well above the expected run length
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge sys_clk);
		wr = 1'b0;
	endtask
	// read data loads on the edge after the strobe, seen at the next falling edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		addr = a;
		rd = 1'b1;
		@(negedge sys_clk);
		rd = 1'b0;
		d = rdata;
	endtask
	// poll status under a bound until the masked bits read as wanted
	task automatic wait_st(input logic [7:0] m, input logic [7:0] w);
		for (int i = 0; i < 2000; i++)
		begin
			rd_reg(8'h12, v);
			if ((v & m) === w)
				break;
		end
		chk8(v & m, w);
	endtask
	// count both one-cycle strobes over a window of sample clocks
	task automatic cnt(input int n);
		cu = 0;
		cf = 0;
		repeat (n)
		begin
			@(negedge sys_clk);
			cu += (upd === 1'b1);
			cf += (fifo_rst === 1'b1);
		end
	endtask
	task automatic t_reset();
		rd_reg(8'h12, v);
		chk8(v, 8'h00);
		rd_reg(8'h10, v);
		chk8(v, 8'h00);
		wr_reg(8'h55, 8'hFF);
		rd_reg(8'h55, v);
		chk8(v, 8'h00);
	endtask
	task automatic t_data_rate();
		int t0;
		wr_reg(8'h10, 8'hC8);
		t0 = cyc;
		rd_reg(8'h12, v);
		chk8(v & 8'h40, 8'h00);
		rd_reg(8'h10, v);
		chk8(v, 8'hC8);
		wait_st(8'h40, 8'h40);
		// no averaging: lock must land inside (11 + 1) times 64..128 sample clocks
		chk8({7'h00, (cyc - t0) >= 12 * 64 && (cyc - t0) <= 12 * 128}, 8'h01);
		// event enables are clear, so the flags show locked high and lost low live
		rd_reg(8'h06, v);
		chk8(v & 8'h30, 8'h10);
		// the synchronised reference edge is taken four sample edges on; phase must be zero there
		@(posedge sync_reference_clock);
		repeat (3) @(negedge sys_clk);
		chk8({2'h0, phase}, 8'h00);
		wr_reg(8'h13, 8'hFF);
		rd_reg(8'h13, v);
		chk8(v, 8'h00);
		cnt(480);
		chk8({7'h00, cu >= 60 && cu <= 68}, 8'h01);
	endtask
	// every delay code, each followed by one frame that must give one fifo reset
	task automatic t_frame();
		for (int d = 0; d < 4; d++)
		begin
			wr_reg(8'h16, 8'(d));
			rd_reg(8'h16, v);
			chk8(v & 8'h03, 8'(d));
			// let the new code cross into the link domain before the frame
			repeat (40) @(negedge sys_clk);
			fork
				mcs_src_model_i.send_frame();
				cnt(100);
			join
			chk8(8'(cf), 8'h01);
		end
	endtask
	task automatic t_fifo_rate();
		// reference sits below data rate over 8, so the fifo rate mode is the better pick
		wr_reg(8'h10, 8'h88);
		rd_reg(8'h10, v);
		chk8(v, 8'h88);
		wait_st(8'h40, 8'h40);
		cnt(480);
		chk8({7'h00, cu >= 7 && cu <= 9}, 8'h01);
	endtask
	// phase slip: lost latches, flags raise a request, relock sets the locked flag
	task automatic t_lost();
		wr_reg(8'h04, 8'h30);
		wr_reg(8'h06, 8'h30);
		mcs_src_model_i.jump();
		wait_st(8'h80, 8'h80);
		chk8({7'h00, evreq}, 8'h01);
		wait_st(8'h40, 8'h40);
		rd_reg(8'h06, v);
		chk8(v & 8'h30, 8'h30);
		wr_reg(8'h06, 8'h30);
		rd_reg(8'h06, v);
		chk8(v & 8'h30, 8'h00);
		chk8({7'h00, evreq}, 8'h00);
		rd_reg(8'h12, v);
		chk8(v & 8'hC0, 8'hC0);
		wr_reg(8'h12, 8'h00);
		rd_reg(8'h12, v);
		chk8(v & 8'hC0, 8'h40);
	endtask
	// falling edge, two-sample averaging: half a period off, one correction, then relock
	task automatic t_avg();
		wr_reg(8'h10, 8'hC1);
		rd_reg(8'h10, v);
		chk8(v, 8'hC1);
		wait_st(8'h80, 8'h80);
		rd_reg(8'h13, v);
		chk8(v, 8'h80);
		wait_st(8'h40, 8'h40);
		rd_reg(8'h13, v);
		chk8(v, 8'h00);
	endtask
	// reset runs past three data clock edges so the link side clears too
	initial
	begin
		sys_rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		repeat (25) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_reset();
		t_data_rate();
		t_frame();
		t_fifo_rate();
		t_lost();
		t_avg();
		test_done();
	end
endmodule // tb_top
